/* File: nac_cfg.svh */
// Register map, field positions, reset values and timing counts of the NVM access block
`ifndef NAC_CFG_SVH
`define NAC_CFG_SVH
// ============================================================
// Register byte offsets on the APB
`define NAC_OFF_DATA_LOW        12'h000
`define NAC_OFF_DATA_HIGH       12'h004
`define NAC_OFF_ADDR_LOW        12'h008
`define NAC_OFF_ADDR_HIGH       12'h00C
`define NAC_OFF_CONTROL         12'h010
`define NAC_OFF_UNLOCK          12'h014
`define NAC_OFF_IRQ             12'h018
// ============================================================
// Control register bit positions
`define NAC_BIT_SPACE           7
`define NAC_BIT_CFGSEL          6
`define NAC_BIT_LATCH           5
`define NAC_BIT_ERASE           4
`define NAC_BIT_FAULT           3
`define NAC_BIT_PENABLE         2
`define NAC_BIT_START           1
`define NAC_BIT_READ            0
// Interrupt register bit positions
`define NAC_BIT_IRQ_FLAG        0
`define NAC_BIT_IRQ_EN          1
// ============================================================
// Reset values
`define NAC_RST_BYTE            8'h00
`define NAC_RST_CONTROL         8'h00
// ============================================================
// Unlock pattern
`define NAC_UNLOCK_FIRST        8'h55
`define NAC_UNLOCK_SECOND       8'hAA
// ============================================================
// Configuration space map
`define NAC_CFG_UID_LO          15'h0000
`define NAC_CFG_UID_HI          15'h0003
`define NAC_CFG_DEVID           15'h0006
`define NAC_CFG_WORD_LO         15'h0007
`define NAC_CFG_WORD_HI         15'h0008
// ============================================================
// Self-timed operation length
`define NAC_PROG_TIME_NS        2000
`define NAC_CLK_PERIOD_NS       25
`define NAC_PROG_CYCLES         ((`NAC_PROG_TIME_NS + `NAC_CLK_PERIOD_NS - 1) / `NAC_CLK_PERIOD_NS)
`endif

/* File: nac_pkg.sv */
// Types shared by the NVM access block
package nac_pkg;

    typedef enum logic [1:0] {
        NAC_IDLE,
        NAC_BUSY,
        NAC_DONE
    } nac_state_t;

    typedef struct packed {
        logic        req;
        logic        write;
        logic        erase;
        logic        latchOnly;
        logic [1:0]  space;
        logic [14:0] addr;
        logic [13:0] wdata;
    } nac_mem_req_t;

endpackage : nac_pkg

/* File: nac_unlock_det.sv */
// Unlock pattern detector fed by writes to the unlock register
`timescale 1ns/1ps
module nac_unlock_det
    import nac_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       clkEn,
    // Register write observation
    input  wire logic       anyWrite,
    input  wire logic       unlockWrite,
    input  wire logic [7:0] wdata,
    // Result
    output logic            unlocked
);

`include "nac_cfg.svh"

    typedef struct packed {
        logic gotFirst;
        logic armed;
    } nac_ulk_state_t;

    nac_ulk_state_t state_reg;
    nac_ulk_state_t state_next;

    // ============================================================
    // Sequence tracking
    // Any other register write breaks the sequence, so the pair must directly precede the start
    always_comb
    begin
        state_next = state_reg;
        if (anyWrite)
        begin
            state_next.gotFirst = 1'b0;
            state_next.armed    = 1'b0;
            if (unlockWrite && wdata == `NAC_UNLOCK_FIRST)
            begin
                state_next.gotFirst = 1'b1;
            end
            else if (unlockWrite && wdata == `NAC_UNLOCK_SECOND && state_reg.gotFirst)
            begin
                state_next.armed = 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_reg <= '0;
        end
        else if (clkEn)
        begin
            state_reg <= state_next;
        end
    end

    assign unlocked = state_reg.armed;

    // ============================================================
    // Checks
    property p_unlock_order;
        @(posedge clk) disable iff (!rst_b)
        $rose(unlocked) |-> $past(unlockWrite) && $past(wdata) == `NAC_UNLOCK_SECOND;
    endproperty
    a_unlock_order: assert property (p_unlock_order) else $error("unlock armed without AAh write");

endmodule : nac_unlock_det

/* File: nac_access_ctrl.sv */
// NVM self-access control registers with APB slave
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "nac_cfg.svh"
module nac_access_ctrl
    import nac_pkg::*;
#(
    parameter int PROG_CYCLES = `NAC_PROG_CYCLES
)
(
    // Clock, enable and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        clkEn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Memory arrays
    output nac_mem_req_t     memReq,
    input  wire logic [13:0] memRdata,
    input  wire logic        memAbort,
    // Core
    output logic             cpuStall,
    output logic             irqOut
);

    typedef struct packed {
        nac_state_t  fsm;
        logic [7:0]  dataLow;
        logic [5:0]  dataHigh;
        logic [7:0]  addrLow;
        logic [6:0]  addrHigh;
        logic        spaceSel;
        logic        cfgSel;
        logic        latchOnly;
        logic        eraseSel;
        logic        fault;
        logic        progEn;
        logic        start;
        logic        readPend;
        logic        irqFlag;
        logic        irqEn;
        logic        stall;
        logic [15:0] timer;
        logic [31:0] rdata;
        logic        slvErr;
        nac_mem_req_t req;
    } nac_state_reg_t;

    nac_state_reg_t st_reg;
    nac_state_reg_t st_next;

    logic        wrAcc;
    logic        rdAcc;
    logic        unlocked;
    logic        mapped;
    logic [14:0] addrWord;
    logic        isEeprom;
    logic        cfgReadOk;
    logic        cfgWriteOk;
    logic [7:0]  ctrlView;
    logic [7:0]  wb;

    assign wrAcc = psel && penable && pwrite && clkEn;
    assign rdAcc = psel && !penable && !pwrite && clkEn;   // Setup cycle: read data then stands through access
    assign wb    = pwdata[7:0];

    assign addrWord  = {st_reg.addrHigh, st_reg.addrLow};
    assign isEeprom  = !st_reg.cfgSel && !st_reg.spaceSel;
    assign cfgReadOk = (addrWord >= `NAC_CFG_UID_LO && addrWord <= `NAC_CFG_UID_HI)
                    || (addrWord >= `NAC_CFG_DEVID && addrWord <= `NAC_CFG_WORD_HI);
    assign cfgWriteOk = addrWord >= `NAC_CFG_UID_LO && addrWord <= `NAC_CFG_UID_HI;

    assign mapped = paddr == `NAC_OFF_DATA_LOW || paddr == `NAC_OFF_DATA_HIGH
                 || paddr == `NAC_OFF_ADDR_LOW || paddr == `NAC_OFF_ADDR_HIGH
                 || paddr == `NAC_OFF_CONTROL || paddr == `NAC_OFF_UNLOCK
                 || paddr == `NAC_OFF_IRQ;

    assign ctrlView = {st_reg.spaceSel, st_reg.cfgSel, st_reg.latchOnly, st_reg.eraseSel,
                       st_reg.fault, st_reg.progEn, st_reg.start, st_reg.readPend};

    // ============================================================
    // Unlock detector
    nac_unlock_det u_unlock (
        .clk         (clk),
        .rst_b       (rst_b),
        .clkEn       (clkEn),
        .anyWrite    (wrAcc),
        .unlockWrite (paddr == `NAC_OFF_UNLOCK),
        .wdata       (wb),
        .unlocked    (unlocked)
    );

    // ============================================================
    // Next state
    always_comb
    begin
        st_next = st_reg;
        st_next.req.req = 1'b0;
        st_next.slvErr  = 1'b0;

        // Register writes
        if (wrAcc)
        begin
            if (paddr == `NAC_OFF_DATA_LOW)
            begin
                st_next.dataLow = wb;
            end
            else if (paddr == `NAC_OFF_DATA_HIGH)
            begin
                st_next.dataHigh = wb[5:0];
            end
            else if (paddr == `NAC_OFF_ADDR_LOW)
            begin
                st_next.addrLow = wb;
            end
            else if (paddr == `NAC_OFF_ADDR_HIGH)
            begin
                st_next.addrHigh = wb[6:0];
            end
            else if (paddr == `NAC_OFF_CONTROL)
            begin
                st_next.spaceSel  = wb[`NAC_BIT_SPACE];
                st_next.cfgSel    = wb[`NAC_BIT_CFGSEL];
                st_next.latchOnly = wb[`NAC_BIT_LATCH];
                st_next.eraseSel  = wb[`NAC_BIT_ERASE];
                st_next.fault     = wb[`NAC_BIT_FAULT];
                st_next.progEn    = wb[`NAC_BIT_PENABLE];
                // Any attempt to set start raises the fault flag; a clean start clears it on completion
                if (wb[`NAC_BIT_START])
                begin
                    st_next.fault = 1'b1;
                    if (st_reg.fsm == NAC_IDLE && wb[`NAC_BIT_PENABLE] && st_reg.progEn && unlocked)
                    begin
                        st_next.start = 1'b1;
                    end
                end
                if (wb[`NAC_BIT_READ] && st_reg.fsm == NAC_IDLE)
                begin
                    st_next.readPend = 1'b1;
                    st_next.req.addr  = addrWord;
                    st_next.req.space = {wb[`NAC_BIT_CFGSEL], wb[`NAC_BIT_SPACE]};
                end
            end
            else if (paddr == `NAC_OFF_IRQ)
            begin
                st_next.irqEn = wb[`NAC_BIT_IRQ_EN];
                // Software clears the done flag by writing one; a new completion that is not latch-only wins
                if (wb[`NAC_BIT_IRQ_FLAG])
                begin
                    st_next.irqFlag = 1'b0;
                end
            end
            else if (paddr != `NAC_OFF_UNLOCK)
            begin
                st_next.slvErr = 1'b1;
            end
        end

        // Register reads
        if (rdAcc)
        begin
            st_next.rdata = 32'h0000_0000;
            if (paddr == `NAC_OFF_DATA_LOW)
            begin
                st_next.rdata[7:0] = st_reg.dataLow;
            end
            else if (paddr == `NAC_OFF_DATA_HIGH)
            begin
                st_next.rdata[5:0] = st_reg.dataHigh;
            end
            else if (paddr == `NAC_OFF_ADDR_LOW)
            begin
                st_next.rdata[7:0] = st_reg.addrLow;
            end
            else if (paddr == `NAC_OFF_ADDR_HIGH)
            begin
                st_next.rdata[6:0] = st_reg.addrHigh;
            end
            else if (paddr == `NAC_OFF_CONTROL)
            begin
                st_next.rdata[7:0] = ctrlView;
            end
            else if (paddr == `NAC_OFF_IRQ)
            begin
                st_next.rdata[1:0] = {st_reg.irqEn, st_reg.irqFlag};
            end
            else if (paddr != `NAC_OFF_UNLOCK)
            begin
                st_next.slvErr = 1'b1;
            end
        end

        // Operation sequencing
        case (st_reg.fsm)
            NAC_IDLE:
            begin
                if (st_reg.readPend)
                begin
                    st_next.readPend = 1'b0;
                    if (st_reg.cfgSel && !cfgReadOk)
                    begin
                        st_next.dataLow  = 8'h00;
                        st_next.dataHigh = 6'h00;
                    end
                    else
                    begin
                        st_next.dataLow  = memRdata[7:0];
                        st_next.dataHigh = isEeprom ? 6'h00 : memRdata[13:8];
                    end
                end
                else if (st_reg.start)
                begin
                    st_next.req.space = {st_reg.cfgSel, st_reg.spaceSel};
                    st_next.req.addr  = addrWord;
                    st_next.req.wdata = {st_reg.dataHigh, st_reg.dataLow};
                    st_next.req.latchOnly = !isEeprom && st_reg.latchOnly;
                    st_next.req.erase     = isEeprom || st_reg.eraseSel;
                    st_next.req.write     = isEeprom || !st_reg.eraseSel;
                    if (st_reg.cfgSel && !cfgWriteOk)
                    begin
                        // Read-only config locations: refuse and leave the fault flag up
                        st_next.start = 1'b0;
                    end
                    else
                    begin
                        st_next.req.req = 1'b1;
                        st_next.stall   = !isEeprom;
                        st_next.timer   = st_next.req.latchOnly ? 16'h0001 : 16'(PROG_CYCLES);
                        st_next.fsm     = NAC_BUSY;
                    end
                end
            end
            NAC_BUSY:
            begin
                if (memAbort)
                begin
                    st_next.start = 1'b0;
                    st_next.fault = 1'b1;
                    st_next.stall = 1'b0;
                    st_next.fsm   = NAC_IDLE;
                end
                else if (st_reg.timer <= 16'h0001)
                begin
                    st_next.fsm = NAC_DONE;
                end
                else
                begin
                    st_next.timer = st_reg.timer - 16'h0001;
                end
            end
            NAC_DONE:
            begin
                st_next.start = 1'b0;
                st_next.fault = wrAcc && paddr == `NAC_OFF_CONTROL && wb[`NAC_BIT_START];
                st_next.stall = 1'b0;
                if (st_reg.req.erase && !isEeprom)
                begin
                    st_next.eraseSel = 1'b0;
                end
                if (!st_reg.req.latchOnly)
                begin
                    st_next.irqFlag = 1'b1;
                end
                st_next.fsm = NAC_IDLE;
            end
            default:
            begin
                st_next.fsm = NAC_IDLE;
            end
        endcase
    end

    // ============================================================
    // State register
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            st_reg <= '0;
        end
        else if (clkEn)
        begin
            st_reg <= st_next;
        end
    end

    assign prdata   = st_reg.rdata;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign memReq   = st_reg.req;
    assign cpuStall = st_reg.stall;
    assign irqOut   = st_reg.irqFlag && st_reg.irqEn;

    // ============================================================
    // Checks
    property p_no_start_locked;
        @(posedge clk) disable iff (!rst_b)
        $rose(st_reg.start) |-> $past(st_reg.progEn) && $past(unlocked);
    endproperty
    a_no_start_locked: assert property (p_no_start_locked) else $error("start without enable/unlock");

    property p_blocked;
        @(posedge clk) disable iff (!rst_b)
        memReq.req |-> $past(st_reg.progEn);
    endproperty
    a_blocked: assert property (p_blocked) else $error("memory request while disabled");

    property p_fault_on_start;
        @(posedge clk) disable iff (!rst_b)
        (wrAcc && paddr == `NAC_OFF_CONTROL && wb[`NAC_BIT_START]) |=> st_reg.fault;
    endproperty
    a_fault_on_start: assert property (p_fault_on_start) else $error("fault not set on start write");

    property p_read_one;
        @(posedge clk) disable iff (!rst_b)
        (clkEn && st_reg.readPend && st_reg.fsm == NAC_IDLE) |=> !st_reg.readPend;
    endproperty
    a_read_one: assert property (p_read_one) else $error("read bit not cleared");

    property p_cfg_zero;
        @(posedge clk) disable iff (!rst_b)
        (clkEn && st_reg.readPend && st_reg.fsm == NAC_IDLE && st_reg.cfgSel && !cfgReadOk)
            |=> st_reg.dataLow == 8'h00 && st_reg.dataHigh == 6'h00;
    endproperty
    a_cfg_zero: assert property (p_cfg_zero) else $error("config read not zeroed");

    property p_eeprom_erase;
        @(posedge clk) disable iff (!rst_b)
        (memReq.req && memReq.space == 2'b00) |-> memReq.erase && memReq.write && !memReq.latchOnly;
    endproperty
    a_eeprom_erase: assert property (p_eeprom_erase) else $error("EEPROM write not erase+write");

    property p_done_clears;
        @(posedge clk) disable iff (!rst_b)
        (clkEn && st_reg.fsm == NAC_DONE) |=> !st_reg.start && !st_reg.stall;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("start not cleared on done");
    property p_high_zero;
        @(posedge clk) disable iff (!rst_b)
        (rdAcc && paddr == `NAC_OFF_DATA_HIGH) |=> prdata[31:6] == 26'h0;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("data high upper bits not zero");

    c_prog: cover property (@(posedge clk) st_reg.fsm == NAC_DONE);
    c_read: cover property (@(posedge clk) st_reg.readPend ##1 !st_reg.readPend);
    c_abort: cover property (@(posedge clk) st_reg.fsm == NAC_BUSY && memAbort);

endmodule : nac_access_ctrl

/* File: nac_mem_model.sv */
// Behavioural model of the flash and data EEPROM arrays
`timescale 1ns/1ps
module nac_mem_model
    import nac_pkg::*;
(
    // Clock and requests
    input  wire logic         clk,
    input  wire nac_mem_req_t memReq,
    input  wire logic         abortCmd,
    // Answers
    output logic [13:0]       memRdata,
    output logic              memAbort
);
    // ============================================================
    // Read path
    // Word is a fixed function of the address so the bench can predict it
    assign memRdata = memReq.addr[13:0] ^ 14'h1555;
    // ============================================================
    // Termination
    // Abort only when a scenario asks for a terminated operation
    always_ff @(posedge clk)
    begin
        memAbort <= abortCmd;
    end
endmodule : nac_mem_model

/* File: test_nvm_access_control_regs.sv */
// Self-checking testbench of the NVM access control registers
`timescale 1ns/1ps
`include "nac_cfg.svh"
module test_nvm_access_control_regs
    import nac_pkg::*;
;
    logic         clk;
    logic         rst_b;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [11:0]  paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    nac_mem_req_t memReq;
    nac_mem_req_t lastReq;
    logic [13:0]  memRdata;
    logic         memAbort;
    logic         cpuStall;
    logic         irqOut;
    logic         abortCmd;
    logic         reqSeen;
    logic         err;
    logic [31:0]  rd;
    int           n_errors;
    int           cmp_count;
    logic [7:0]   ctl [5] = '{8'h06, 8'h96, 8'hA6, 8'h86, 8'hC6};
    logic [3:0]   fld [5] = '{4'h2, 4'h6, 4'h5, 4'h4, 4'hC};
    logic [3:0]   msk [5] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'hF};
    logic [7:0]   aft [5] = '{8'h04, 8'h84, 8'hA4, 8'h84, 8'hC4};

    nac_access_ctrl #(.PROG_CYCLES(4)) dut_u (.clk(clk), .rst_b(rst_b), .clkEn(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .memReq(memReq), .memRdata(memRdata), .memAbort(memAbort), .cpuStall(cpuStall),
        .irqOut(irqOut));
    nac_mem_model mem_u (.clk(clk), .memReq(memReq), .abortCmd(abortCmd), .memRdata(memRdata),
        .memAbort(memAbort));

    // ============================================================
    // Clock, request monitor and watchdog
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // The request pulse lasts one cycle, so it is caught here rather than polled
    always @(posedge clk)
    begin
        if (memReq.req === 1'b1)
        begin
            reqSeen <= 1'b1;
            lastReq <= memReq;
        end
    end
    initial
    begin
        #(25 * 20000);
        n_errors++;
        give_verdict();
    end

    // ============================================================
    // Tasks
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        err = pslverr;
        rd  = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        // One idle edge between transfers so no strobe is assigned twice in a time step
        @(posedge clk);
    endtask : apb
    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, d);
    endtask : wr
    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(a, 1'b0, 8'h00);
        chk(rd, e);
    endtask : rdc
    task unlock;
        wr(`NAC_OFF_UNLOCK, 8'h55);
        wr(`NAC_OFF_UNLOCK, 8'hAA);
    endtask : unlock
    task wait_idle;
        for (int k = 0; k < 20; k++)
        begin
            apb(`NAC_OFF_CONTROL, 1'b0, 8'h00);
            if (rd[1] === 1'b0)
                break;
        end
    endtask : wait_idle
    task give_verdict;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    // ============================================================
    // Scenarios
    initial
    begin
        {rst_b, psel, penable, pwrite, paddr, pwdata, abortCmd, reqSeen} = '0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rdc(`NAC_OFF_ADDR_LOW, 32'h0);
        rdc(`NAC_OFF_CONTROL, 32'h0);
        wr(`NAC_OFF_UNLOCK, 8'h5A);
        rdc(`NAC_OFF_UNLOCK, 32'h0);
        wr(`NAC_OFF_DATA_HIGH, 8'hFF);
        rdc(`NAC_OFF_DATA_HIGH, 32'h3F);
        wr(`NAC_OFF_DATA_LOW, 8'hA5);
        rdc(`NAC_OFF_DATA_LOW, 32'hA5);
        wr(`NAC_OFF_ADDR_HIGH, 8'hFF);
        rdc(`NAC_OFF_ADDR_HIGH, 32'h7F);
        wr(`NAC_OFF_ADDR_HIGH, 8'h00);
        wr(`NAC_OFF_ADDR_LOW, 8'h00);
        wr(`NAC_OFF_CONTROL, 8'h02);
        rdc(`NAC_OFF_CONTROL, 32'h08);
        chk(reqSeen, 1'b0);
        // Unlock pair split by another register write must not unlock
        wr(`NAC_OFF_CONTROL, 8'h04);
        wr(`NAC_OFF_UNLOCK, 8'h55);
        wr(`NAC_OFF_DATA_LOW, 8'hA5);
        wr(`NAC_OFF_UNLOCK, 8'hAA);
        wr(`NAC_OFF_CONTROL, 8'h06);
        rdc(`NAC_OFF_CONTROL, 32'h0C);
        chk(reqSeen, 1'b0);
        wr(`NAC_OFF_IRQ, 8'h02);
        for (int i = 0; i < 5; i++)
        begin
            wr(`NAC_OFF_CONTROL, ctl[i] & 8'hFD);
            unlock();
            reqSeen = 1'b0;
            wr(`NAC_OFF_CONTROL, ctl[i]);
            @(posedge clk);
            chk(cpuStall, ctl[i][7] | ctl[i][6]);
            wait_idle();
            chk(rd, aft[i]);
            chk(reqSeen, 1'b1);
            chk({lastReq.space, lastReq.erase, lastReq.latchOnly} & msk[i], fld[i]);
        end
        rdc(`NAC_OFF_IRQ, 32'h03);
        chk(irqOut, 1'b1);
        wr(`NAC_OFF_IRQ, 8'h03);
        chk(irqOut, 1'b0);
        wr(`NAC_OFF_ADDR_LOW, 8'h3C);
        wr(`NAC_OFF_ADDR_HIGH, 8'h12);
        wr(`NAC_OFF_CONTROL, 8'h81);
        rdc(`NAC_OFF_CONTROL, 32'h80);
        rdc(`NAC_OFF_DATA_LOW, 32'h69);
        rdc(`NAC_OFF_DATA_HIGH, 32'h07);
        wr(`NAC_OFF_ADDR_LOW, 8'h05);
        wr(`NAC_OFF_ADDR_HIGH, 8'h00);
        wr(`NAC_OFF_CONTROL, 8'hC1);
        rdc(`NAC_OFF_DATA_LOW, 32'h0);
        rdc(`NAC_OFF_DATA_HIGH, 32'h0);
        // Configuration words are read-only
        wr(`NAC_OFF_ADDR_LOW, 8'h07);
        wr(`NAC_OFF_CONTROL, 8'hC4);
        unlock();
        reqSeen = 1'b0;
        wr(`NAC_OFF_CONTROL, 8'hC6);
        rdc(`NAC_OFF_CONTROL, 32'hCC);
        chk(reqSeen, 1'b0);
        wr(`NAC_OFF_ADDR_LOW, 8'h00);
        wr(`NAC_OFF_CONTROL, 8'h84);
        unlock();
        wr(`NAC_OFF_CONTROL, 8'h86);
        abortCmd <= 1'b1;
        wait_idle();
        abortCmd <= 1'b0;
        chk(rd, 32'h8C);
        apb(12'h01C, 1'b1, 8'h00);
        chk(err, 1'b1);
        give_verdict();
    end
endmodule : test_nvm_access_control_regs
